/* rtl/pfs_ctrl.v */
// Purpose: processor self read/write sequencer for on-chip program flash
// Assumes: flash array answers reads after a fixed time, no handshake
// Notes:   erase and program of a row are timed here, not by software
//
// Function
// - flash reached only through seven registers
// - data pair forms one 14-bit word
// - address pair forms 13-bit word address
// - 2K words implemented, 0000h to 07FFh
// - address pair spans 8K words
// - read one word, write four words
// - row write erases first, then programs
// - internal timer sets erase/write duration
// - start bits set only, zero ignored
// - hardware clears start bits at completion
// - write needs write-allow; clear after reset
// - key register reads all zeros
// - key register used only for writes
// - self access works under code protection
// - protect bits block writes, never reads
// - code protect shuts out serial programmer
`timescale 1ns/100ps
`include "pfs_defines.vh"
module pfs_ctrl (
  mclk,
  rst_b,
  clk_en,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  block_write_protect_sel,
  code_protect_n,
  prog_access_req,
  prog_access_ok,
  fl_addr,
  fl_wdata,
  fl_rdata,
  fl_read,
  fl_erase,
  fl_prog,
  fl_pump_on
);
  input         mclk;                    // system clock
  input         rst_b;                   // async reset, active low
  input         clk_en;                  // freezes all state when low
  input  [2:0]  reg_addr;                // register index
  input  [7:0]  reg_wdata;               // write data
  input         reg_wr;                  // write strobe
  input         reg_rd;                  // read strobe
  output [7:0]  reg_rdata;               // read data, cycle after strobe
  input  [1:0]  block_write_protect_sel; // write protect configuration
  input         code_protect_n;          // code protect, active low
  input         prog_access_req;         // serial programmer wants access
  output        prog_access_ok;          // serial programmer admitted
  output [10:0] fl_addr;                 // array word address
  output [13:0] fl_wdata;                // array write word
  input  [13:0] fl_rdata;                // array read word
  output        fl_read;                 // array read enable
  output        fl_erase;                // row erase
  output        fl_prog;                 // word program
  output        fl_pump_on;              // charge pump enable

  // one-hot states
  localparam [5:0] ST_IDLE  = 6'h01;
  localparam [5:0] ST_READ  = 6'h02;
  localparam [5:0] ST_ERASE = 6'h04;
  localparam [5:0] ST_PROG  = 6'h08;
  localparam [5:0] ST_NEXT  = 6'h10;
  localparam [5:0] ST_DONE  = 6'h20;

  reg    [5:0]  st_q;          // sequencer state
  reg    [5:0]  st_d;          // next state
  reg    [7:0]  addr_lo_q;     // address low byte
  reg    [4:0]  addr_hi_q;     // address high bits
  reg    [7:0]  data_lo_q;     // data low byte
  reg    [5:0]  data_hi_q;     // data high bits
  reg           rd_q;          // read start bit
  reg           wr_q;          // write start bit
  reg           write_allow_bit_q;        // write_allow_bit
  reg           wrerr_q;       // sticky: write refused
  reg    [1:0]  key_q;         // key progress
  wire   [41:0] row_flat;      // first three words of a row, word 0 low
  reg    [1:0]  widx_q;        // word being programmed
  reg    [7:0]  rdata_q;       // read data register
  reg    [10:0] fl_addr_q;     // array address
  reg    [13:0] fl_wdata_q;    // array write data
  reg           fl_read_q;     // array read
  reg           fl_erase_q;    // array erase
  reg           fl_prog_q;     // array program
  reg           pump_q;        // charge pump
  reg           acc_ok_q;      // programmer access
  reg           tmr_load;      // timer start
  reg    [23:0] tmr_count;     // timer interval
  reg           wr_ok;         // write accepted
  reg           blk_prot;      // address write protected
  wire          tmr_done;      // interval done
  wire   [12:0] word_addr;     // full 13-bit address
  wire   [13:0] data_word;     // full 14-bit word
  wire          wr_ctl;        // control write strobe
  wire   [10:0] row_base;      // first word of the row
  genvar        gi;

  assign word_addr = {addr_hi_q, addr_lo_q};
  assign data_word = {data_hi_q, data_lo_q};
  assign wr_ctl    = reg_wr && (reg_addr == `PFS_REG_CONTROL);
  assign row_base  = {word_addr[10:2], 2'b00};
  assign reg_rdata      = rdata_q;
  assign prog_access_ok = acc_ok_q;
  assign fl_addr        = fl_addr_q;
  assign fl_wdata       = fl_wdata_q;
  assign fl_read        = fl_read_q;
  assign fl_erase       = fl_erase_q;
  assign fl_prog        = fl_prog_q;
  assign fl_pump_on     = pump_q;

  //////////////////////////////////////////////////////////////////////////
  // interval timer for read access, erase and program
  pfs_timer u_tmr (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .clk_en (clk_en),
    .load   (tmr_load),
    .count  (tmr_count),
    .done   (tmr_done)
  );

  //////////////////////////////////////////////////////////////////////////
  // protection: quarters of the 2K array, code protect never blocks self
  always @* begin
    case (block_write_protect_sel)
      2'b11:   blk_prot = 1'b0;                       // none protected
      2'b10:   blk_prot = (word_addr[10:9] == 2'b00); // first quarter
      2'b01:   blk_prot = (word_addr[10] == 1'b0);    // first half
      default: blk_prot = 1'b1;                       // all protected
    endcase
  end

  // write starts only with allow bit, key done, legal address
  always @* begin
    wr_ok = write_allow_bit_q && (key_q == 2'b10) && !blk_prot &&
            (word_addr[12:11] == 2'b00);
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencer next state and timer loads
  always @* begin
    st_d      = st_q;
    tmr_load  = 1'b0;
    tmr_count = 24'h000000;
    case (st_q)
      ST_IDLE: begin
        if (wr_q && word_addr[1:0] == 2'b11) begin
          st_d      = ST_ERASE;
          tmr_load  = 1'b1;
          tmr_count = `PFS_ERASE_CYC;
        end else if (wr_q) begin
          st_d = ST_DONE; // word buffered only
        end else if (rd_q) begin
          st_d      = ST_READ;
          tmr_load  = 1'b1;
          tmr_count = `PFS_READ_CYC;
        end
      end
      ST_READ: begin
        if (tmr_done) st_d = ST_DONE;
      end
      ST_ERASE: begin
        if (tmr_done) begin
          st_d      = ST_PROG;
          tmr_load  = 1'b1;
          tmr_count = `PFS_PROG_CYC;
        end
      end
      ST_PROG: begin
        if (tmr_done) st_d = (widx_q == 2'b11) ? ST_DONE : ST_NEXT;
      end
      ST_NEXT: begin
        st_d      = ST_PROG; // four words per row
        tmr_load  = 1'b1;
        tmr_count = `PFS_PROG_CYC;
      end
      ST_DONE: st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // row buffer, one entry per leading word of a row
  generate
    for (gi = 0; gi < `PFS_ROW_WORDS - 1; gi = gi + 1) begin : g_row
      localparam [1:0] SLOT = gi; // position of this word in the row
      reg [13:0] word_q;          // held until the fourth word arrives
      // one process per entry, so no entry has two drivers
      always @(posedge mclk) begin
        if (clk_en && st_q == ST_IDLE && wr_q &&
            word_addr[1:0] == SLOT) begin
          word_q <= data_word;
        end
      end
      assign row_flat[gi*14 +: 14] = word_q;
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // registers, sequencer, array drive
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q       <= ST_IDLE;
      addr_lo_q  <= 8'h00;
      addr_hi_q  <= 5'h00;
      data_lo_q  <= 8'h00;
      data_hi_q  <= 6'h00;
      rd_q       <= 1'b0;
      wr_q       <= 1'b0;
      write_allow_bit_q     <= 1'b0; // clear after power-up
      wrerr_q    <= 1'b0;
      key_q      <= 2'b00;
      widx_q     <= 2'b00;
      rdata_q    <= 8'h00;
      fl_addr_q  <= 11'h000;
      fl_wdata_q <= 14'h0000;
      fl_read_q  <= 1'b0;
      fl_erase_q <= 1'b0;
      fl_prog_q  <= 1'b0;
      pump_q     <= 1'b0;
      acc_ok_q   <= 1'b0;
    end else if (clk_en) begin
      st_q     <= st_d;
      // programmer shut out while code protect is enabled (low)
      acc_ok_q <= prog_access_req && code_protect_n;
      // register read, data the next cycle only
      rdata_q  <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `PFS_REG_CONTROL: rdata_q <= {4'h0, wrerr_q, write_allow_bit_q, wr_q, rd_q};
          `PFS_REG_KEY:     rdata_q <= 8'h00; // no storage
          `PFS_REG_DATA_LO: rdata_q <= data_lo_q;
          `PFS_REG_DATA_HI: rdata_q <= {2'b00, data_hi_q};
          `PFS_REG_ADDR_LO: rdata_q <= addr_lo_q;
          `PFS_REG_ADDR_HI: rdata_q <= {3'b000, addr_hi_q};
          `PFS_REG_STATUS:  rdata_q <= {2'b00, st_q};
          default:          rdata_q <= 8'h00;
        endcase
      end
      // address and data pairs
      if (reg_wr && reg_addr == `PFS_REG_ADDR_LO) addr_lo_q <= reg_wdata;
      if (reg_wr && reg_addr == `PFS_REG_ADDR_HI)
        addr_hi_q <= reg_wdata[4:0];
      if (reg_wr && reg_addr == `PFS_REG_DATA_LO) data_lo_q <= reg_wdata;
      if (reg_wr && reg_addr == `PFS_REG_DATA_HI)
        data_hi_q <= reg_wdata[5:0];
      // key: first then second byte, anything else restarts
      if (reg_wr && reg_addr == `PFS_REG_KEY) begin
        if (reg_wdata == `PFS_KEY_FIRST)
          key_q <= 2'b01;
        else if (reg_wdata == `PFS_KEY_SECOND && key_q == 2'b01)
          key_q <= 2'b10;
        else
          key_q <= 2'b00;
      end else if (reg_wr) begin
        key_q <= 2'b00; // key must come right before the start
      end
      // control: allow bit writes both ways, start bits set only
      if (wr_ctl) begin
        write_allow_bit_q <= reg_wdata[`PFS_CTL_WRITE_ALLOW_BIT];
        if (reg_wdata[`PFS_CTL_WRERR] == 1'b0) wrerr_q <= 1'b0;
        if (reg_wdata[`PFS_CTL_RD] && !rd_q && !wr_q)
          rd_q <= 1'b1; // zero ignored
        if (reg_wdata[`PFS_CTL_WR] && !rd_q && !wr_q) begin
          if (wr_ok) begin
            wr_q <= 1'b1;
          end else begin
            wrerr_q <= 1'b1; // refused, bit stays clear
          end
        end
      end
      // array drive per state
      fl_read_q  <= (st_d == ST_READ);
      fl_erase_q <= (st_d == ST_ERASE);
      fl_prog_q  <= (st_d == ST_PROG);
      pump_q     <= (st_d == ST_ERASE) || (st_d == ST_PROG);
      if (st_q == ST_IDLE && rd_q)
        fl_addr_q <= word_addr[10:0]; // upper bits beyond 2K ignored
      if (st_q == ST_IDLE && wr_q && word_addr[1:0] == 2'b11) begin
        fl_addr_q <= row_base;
        widx_q    <= 2'b00;
      end
      if (st_d == ST_PROG && st_q != ST_PROG) begin
        fl_addr_q  <= {row_base[10:2], widx_q};
        fl_wdata_q <= (widx_q == 2'b11) ? data_word
                                        : row_flat[widx_q*14 +: 14];
      end
      if (st_q == ST_PROG && tmr_done) widx_q <= widx_q + 2'b01;
      // read data lands in the pair
      if (st_q == ST_READ && tmr_done) begin
        data_lo_q <= fl_rdata[7:0];
        data_hi_q <= fl_rdata[13:8];
      end
      // completion clears the start bits
      if (st_q == ST_DONE) begin
        rd_q <= 1'b0;
        wr_q <= 1'b0;
      end
    end
  end
endmodule // pfs_ctrl

/* rtl/pfs_defines.vh */
// Purpose: constants for the program flash self read/write controller
// Assumes: 8-bit register port, 14-bit flash words, 2K-word array
// Notes:   offsets and key values are local choices
`ifndef PFS_DEFINES_VH
`define PFS_DEFINES_VH

// register indices on the 3-bit software port
`define PFS_REG_CONTROL   3'h0
`define PFS_REG_KEY       3'h1
`define PFS_REG_DATA_LO   3'h2
`define PFS_REG_DATA_HI   3'h3
`define PFS_REG_ADDR_LO   3'h4
`define PFS_REG_ADDR_HI   3'h5
`define PFS_REG_STATUS    3'h6

// control register bit positions
`define PFS_CTL_RD        0
`define PFS_CTL_WR        1
`define PFS_CTL_WRITE_ALLOW_BIT      2
`define PFS_CTL_WRERR     3

// reset values
`define PFS_CTL_RST       8'h00
`define PFS_ADDR_RST      13'h0000
`define PFS_DATA_RST      14'h0000

// write unlock key, two bytes in order
`define PFS_KEY_FIRST     8'h55
`define PFS_KEY_SECOND    8'hAA

// array geometry
`define PFS_ADDR_W        13
`define PFS_IMPL_W        11
`define PFS_DATA_W        14
`define PFS_ROW_WORDS     4

// flash timing: read access and erase/write times
`define PFS_CLK_NS        50
`define PFS_READ_NS       100
`define PFS_ERASE_NS      2000000
`define PFS_PROG_NS       2000000
// the same times in clock cycles, rounded up, sized for the 24-bit timer
`define PFS_READ_CYC      24'h000002
`define PFS_ERASE_CYC     24'h009C40
`define PFS_PROG_CYC      24'h009C40

`endif

/* rtl/pfs_timer.v */
// Purpose: one-shot down counter that paces flash operations
// Assumes: load and run are exclusive in any cycle
// Notes:   done pulses one cycle when the count runs out
`timescale 1ns/100ps
module pfs_timer (
  mclk,
  rst_b,
  clk_en,
  load,
  count,
  done
);
  input         mclk;   // system clock
  input         rst_b;  // async reset, active low
  input         clk_en; // freeze when low
  input         load;   // start a new interval
  input  [23:0] count;  // interval length in cycles
  output        done;   // one-cycle end pulse

  reg    [23:0] cnt_q;  // cycles remaining
  reg           run_q;  // counting
  reg           done_q; // end pulse

  assign done = done_q;

  //////////////////////////////////////////////////////////////////////////
  // count down, pulse when the count reaches one
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q  <= 24'h000000;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= 1'b0;
      if (load) begin
        cnt_q <= count;
        run_q <= 1'b1;
      end else if (run_q) begin
        // interval ends when one cycle remains
        if (cnt_q <= 24'h000001) begin
          run_q  <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 24'h000001;
        end
      end
    end
  end
endmodule // pfs_timer

/* verif/pfs_ctrl_checker.sv */
// Purpose: port assertions for the flash self read/write controller
// Assumes: one clock mclk, asynchronous active-low rst_b
// Notes:   bound onto pfs_ctrl below the module
`timescale 1ns/100ps
module pfs_ctrl_checker (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        clk_en,
  input wire logic [2:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [1:0]  block_write_protect_sel,
  input wire logic        code_protect_n,
  input wire logic        prog_access_req,
  input wire logic        prog_access_ok,
  input wire logic [10:0] fl_addr,
  input wire logic [13:0] fl_wdata,
  input wire logic [13:0] fl_rdata,
  input wire logic        fl_read,
  input wire logic        fl_erase,
  input wire logic        fl_prog,
  input wire logic        fl_pump_on
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  // read start taken while the array is idle
  sequence s_rd_go;
    clk_en && reg_wr && reg_addr == 3'h0 && reg_wdata[0]
      && !fl_read && !fl_erase && !fl_prog;
  endsequence
  // a single word read ends quickly
  sequence s_rd_end;
    ##[1:4] !fl_read;
  endsequence
  a_read_starts: assert property (s_rd_go |-> ##[1:3] fl_read)
    else $error("read start gave no array read");
  a_read_ends: assert property ($rose(fl_read) |-> s_rd_end)
    else $error("array read too long");
  a_read_addr: assert property (fl_read && $past(fl_read) |-> $stable(fl_addr))
    else $error("address moved during read");
  a_rdata_idle: assert property (!$past(reg_rd && clk_en) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_key_zero: assert property ($past(reg_rd && clk_en && reg_addr == 3'h1)
    |-> reg_rdata == 8'h00)
    else $error("key register read nonzero");
  a_prog_gate: assert property ($past(rst_b && clk_en) |->
    prog_access_ok == $past(prog_access_req && code_protect_n))
    else $error("programmer gate wrong");
  a_pump_erase: assert property (fl_erase |-> fl_pump_on)
    else $error("erase without pump");
  a_pump_prog: assert property (fl_prog |-> fl_pump_on)
    else $error("program without pump");
  a_one_op: assert property ($onehot0({fl_read, fl_erase, fl_prog}))
    else $error("array operations overlap");
  a_protect_all: assert property (block_write_protect_sel == 2'b00
    |-> !$rose(fl_erase))
    else $error("erase in protected setting");
endmodule // pfs_ctrl_checker

bind pfs_ctrl pfs_ctrl_checker u_chk (.mclk, .rst_b, .clk_en, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .block_write_protect_sel,
  .code_protect_n, .prog_access_req, .prog_access_ok, .fl_addr, .fl_wdata,
  .fl_rdata, .fl_read, .fl_erase, .fl_prog, .fl_pump_on);

/* verif/pfs_flash_model.sv */
// Purpose: behavioural flash array facing pfs_ctrl
// Assumes: erase sets a row to ones, program only clears bits
// Notes:   released read bus shows the inverse of the last word
`timescale 1ns/100ps
module pfs_flash_model (
  input wire logic        mclk,
  input wire logic [10:0] fl_addr,
  input wire logic [13:0] fl_wdata,
  input wire logic        fl_read,
  input wire logic        fl_erase,
  input wire logic        fl_prog,
  output logic     [13:0] fl_rdata
);
  logic [13:0] mem [0:2047];      // 2K words
  logic [13:0] last_q = 14'h0000; // last word driven
  integer      i;                 // preload index
  integer      j;                 // row index
  ////////////////////////////////////////
  // pattern the bench can work out on its own
  initial begin
    for (i = 0; i < 2048; i = i + 1) begin
      mem[i] = 14'(i * 37 + 5);
    end
  end
  // floating bus would let X settle by chance, so invert
  assign fl_rdata = fl_read ? mem[fl_addr] : ~last_q;
  // erase the whole row, program word by word
  always @(posedge mclk) begin
    if (fl_read) begin
      last_q <= mem[fl_addr];
    end
    if (fl_erase) begin
      for (j = 0; j < 4; j = j + 1) begin
        mem[{fl_addr[10:2], 2'(j)}] <= 14'h3FFF;
      end
    end
    if (fl_prog) begin
      mem[fl_addr] <= mem[fl_addr] & fl_wdata;
    end
  end
endmodule // pfs_flash_model

/* verif/tb_top.sv */
// Purpose: self-checking bench for the flash self read/write controller
// Assumes: key 55h then AAh, control at index 0
// Notes:   a row program outlasts the run, so it stops at the first word
`timescale 1ns/100ps
module tb_top;
  logic        mclk = 1'b0;               // 20 MHz clock
  logic        rst_b = 1'b0;              // reset, active low
  logic        clk_en = 1'b1;             // held on except during the freeze test
  logic [2:0]  reg_addr = 3'h0;           // register index
  logic [7:0]  reg_wdata = 8'h00;         // write data
  logic        reg_wr = 1'b0;             // write strobe
  logic        reg_rd = 1'b0;             // read strobe
  logic [7:0]  reg_rdata;                 // read data
  logic [1:0]  block_write_protect_sel = 2'b11;
  logic        code_protect_n = 1'b1;     // active low
  logic        prog_access_req = 1'b0;    // programmer request
  logic        prog_access_ok;            // checked by the checker
  logic [10:0] fl_addr;                   // array address
  logic [13:0] fl_wdata;                  // array write word
  logic [13:0] fl_rdata;                  // array read word
  logic        fl_read, fl_erase, fl_prog, fl_pump_on;
  integer      seed = 40;
  integer      n_fail = 0;
  integer      comparisons = 0;
  integer      n_er = 0;                  // erase starts seen
  logic        er_q = 1'b0;
  logic [7:0]  d, lo, hi;
  logic [10:0] a;
  integer      c, w;
  logic [13:0] row_exp [$];               // words a row write programs
  ////////////////////////////////////////
  pfs_ctrl dut (.mclk, .rst_b, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .block_write_protect_sel, .code_protect_n,
    .prog_access_req, .prog_access_ok, .fl_addr, .fl_wdata, .fl_rdata,
    .fl_read, .fl_erase, .fl_prog, .fl_pump_on);
  pfs_flash_model u_flash (.mclk, .fl_addr, .fl_wdata, .fl_read, .fl_erase,
    .fl_prog, .fl_rdata);
  initial begin
    forever #25 mclk = ~mclk;
  end
  // count erase starts, random programmer requests
  always @(posedge mclk) begin
    er_q <= fl_erase;
    if (fl_erase && !er_q) begin
      n_er <= n_er + 1;
    end
    prog_access_req <= 1'($random(seed));
  end
  task chk(input string nm, input logic [13:0] e, input logic [13:0] g);
    comparisons = comparisons + 1;
    if (g !== e) begin
      n_fail = n_fail + 1;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [2:0] ra, input logic [7:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= ra;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task rd(input logic [2:0] ra, output logic [7:0] v);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= ra;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task wait_clr(input integer b);
    integer k;
    for (k = 0; k < 40; k = k + 1) begin
      rd(3'h0, d);
      if (d[b] === 1'b0) return;
    end
    chk("start bit timeout", 14'h0, 14'h1);
    wrap_up;
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    rd(3'h0, d);
    chk("control", 14'h0, d);
    rd(3'h1, d);
    chk("key", 14'h0, d);
    wr(3'h5, 8'hFF);
    wr(3'h3, 8'hFF);
    rd(3'h5, d);
    chk("addr high", 14'h1F, d);
    rd(3'h3, d);
    chk("data high", 14'h3F, d);
    $display("test registers done");
    code_protect_n <= 1'b0;
    for (c = 0; c < 4; c = c + 1) begin
      a = (c == 0) ? 11'h7FF : 11'($random(seed));
      wr(3'h4, a[7:0]);
      wr(3'h5, {5'h00, a[10:8]});
      wr(3'h0, 8'h01);
      wait_clr(0);
      rd(3'h2, lo);
      rd(3'h3, hi);
      chk("word", 14'(a * 37 + 5), {hi[5:0], lo});
    end
    $display("test reads done");
    code_protect_n <= 1'b1;
    // no key, no allow, beyond array, all protected
    for (c = 0; c < 4; c = c + 1) begin
      block_write_protect_sel <= (c == 3) ? 2'b00 : 2'b11;
      wr(3'h5, (c == 2) ? 8'h08 : 8'h00);
      wr(3'h0, (c == 1) ? 8'h00 : 8'h04);
      if (c != 0) begin
        wr(3'h1, 8'h55);
        wr(3'h1, 8'hAA);
      end
      wr(3'h0, (c == 1) ? 8'h02 : 8'h06);
      rd(3'h0, d);
      chk("refused", 14'h2, {d[3], d[1]});
    end
    chk("erases", 14'h0, 14'(n_er));
    $display("test refusals done");
    block_write_protect_sel <= 2'b11;
    wr(3'h5, 8'h00);
    for (w = 0; w < 4; w = w + 1) begin
      wr(3'h4, 8'h10 + w[7:0]);
      lo = 8'($random(seed));
      wr(3'h2, lo);
      row_exp.push_back({6'h15, lo});
      wr(3'h3, 8'h15);
      wr(3'h0, 8'h04);
      wr(3'h1, 8'h55);
      wr(3'h1, 8'hAA);
      wr(3'h0, 8'h06);
      if (w < 3) begin
        wait_clr(1);
        chk("early erase", 14'h0, 14'(n_er));
      end
    end
    for (c = 0; c < 10 && !fl_erase; c = c + 1) @(posedge mclk);
    #1 chk("erase pump", 14'h3, {fl_erase, fl_pump_on});
    chk("erase row", 14'h4, fl_addr[10:2]);
    chk("row erased", 14'h3FFF, u_flash.mem[16]);
    wr(3'h0, 8'h04);
    rd(3'h0, d);
    chk("write busy", 14'h1, d[1]);
    // freeze: strobes are ignored and read data stays at zero
    @(posedge mclk);
    clk_en <= 1'b0;
    wr(3'h4, 8'h00);
    rd(3'h0, d);
    chk("frozen read", 14'h0, d);
    clk_en <= 1'b1;
    rd(3'h4, d);
    chk("frozen write", 14'h13, d);
    for (c = 0; c < 40100 && !fl_prog; c = c + 1) @(posedge mclk);
    #1 chk("prog start", 14'h3, {fl_erase, fl_prog, fl_pump_on});
    chk("prog addr", 14'h10, fl_addr);
    chk("prog word", row_exp[0], fl_wdata);
    $display("test row write done");
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk("reset stops", 14'h0, {fl_erase, fl_prog, fl_pump_on});
    rst_b <= 1'b1;
    rd(3'h0, d);
    chk("control", 14'h0, d);
    $display("test reset done");
    wrap_up;
  end
endmodule // tb_top
